// ==== hw/autoneg_consts.svh ====
`ifndef AUTONEG_CONSTS_SVH
`define AUTONEG_CONSTS_SVH

// Register offsets on the management frame
`define ADV_OFS        5'h04
`define LP_OFS         5'h05
`define EXP_OFS        5'h06
`define REV_OFS        5'h10

// Advertisement word fields
`define ADV_NP_BIT     15
`define ADV_RF_BIT     13
`define ADV_PAUSE_HI   11
`define ADV_PAUSE_LO   10
`define ADV_T4_BIT     9
`define ADV_100FD_BIT  8
`define ADV_100HD_BIT  7
`define ADV_10FD_BIT   6
`define ADV_10HD_BIT   5
`define SEL_HI         4

// Partner word fields
`define LP_NP_BIT      15
`define LP_ACK_BIT     14
`define LP_RF_BIT      13
`define LP_PAUSE_BIT   10
`define LP_T4_BIT      9

// Expansion word fields
`define EXP_PDF_BIT    4
`define EXP_LPNP_BIT   3
`define EXP_NPA_BIT    2
`define EXP_PR_BIT     1
`define EXP_LPAN_BIT   0

// Revision field position
`define REV_LSB        6

// Reset values
`define SEL_RST        5'h01
`define PAUSE_RST      2'h0
`define HD100_RST      1'h1

// Management frame counts
`define PRE_ONES       6'h20
`define HDR_LAST       5'h0b
`define DATA_LAST      5'h0f
`define DATA_END       5'h10
`define STRAP_WAIT     2'h3

// Frame opcodes
`define OP_RD          2'h2
`define OP_WR          2'h1

`endif

// ==== hw/autoneg_pkg.sv ====
`default_nettype none

package autoneg_pkg;

  typedef enum logic [2:0] {
    PRE, START, HDR, TA, RDATA, WTA, WDATA
  } smi_state_type;

  typedef struct packed {
    smi_state_type state;
    logic          mdc_prev;
    logic [5:0]    ones;
    logic [4:0]    cnt;
    logic [15:0]   sh;
    logic [4:0]    reg_ofs;
    logic          mdio_o;
    logic          mdio_oe;
    logic          adv_rf;
    logic [1:0]    adv_pause;
    logic          adv_100fd;
    logic          adv_100hd;
    logic          adv_10fd;
    logic          adv_10hd;
    logic [4:0]    adv_sel;
    logic          lp_ack;
    logic          lp_rf;
    logic          lp_pause;
    logic          lp_100fd;
    logic          lp_100hd;
    logic          lp_10fd;
    logic          lp_10hd;
    logic [4:0]    lp_sel;
    logic          exp_lpnp;
    logic          exp_lpan;
    logic [1:0]    strap_cnt;
    logic          strap_done;
  } mgmt_state_type;

  typedef struct packed {
    logic flag;
  } flag_state_type;

  typedef struct packed {
    logic [9:0] s1;
    logic [9:0] s2;
  } sync_state_type;

endpackage

`default_nettype wire

// ==== hw/pin_bus_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface pin_bus_if;
  logic       mdc_raw;
  logic       mdio_raw;
  logic [4:0] addr_raw;
  logic [2:0] strap_raw;
  logic       mdc;
  logic       mdio;
  logic [4:0] addr;
  logic [2:0] strap;

  modport sync (input mdc_raw, mdio_raw, addr_raw, strap_raw,
                output mdc, mdio, addr, strap);
  modport core (input mdc, mdio, addr, strap);
endinterface

`default_nettype wire

// ==== hw/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
  input  wire logic   mclk_in,  // System clock
  input  wire logic   reset_in, // Async reset, high
  pin_bus_if.sync     pins      // Raw and synced pins
);

  autoneg_pkg::sync_state_type st_reg;
  autoneg_pkg::sync_state_type st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = {pins.mdc_raw, pins.mdio_raw, pins.addr_raw, pins.strap_raw};
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pins.mdc   = st_reg.s2[9];
  assign pins.mdio  = st_reg.s2[8];
  assign pins.addr  = st_reg.s2[7:3];
  assign pins.strap = st_reg.s2[2:0];

endmodule // pin_sync

`default_nettype wire

// ==== hw/latch_flag.sv ====
`timescale 1ns/1ps
`default_nettype none

module latch_flag (
  input  wire logic mclk_in,  // System clock
  input  wire logic reset_in, // Async reset, high
  input  wire logic set_in,   // Event pulse
  input  wire logic clr_in,   // Clear on read pulse
  output logic      flag_out  // Latched flag
);

  autoneg_pkg::flag_state_type st_reg;
  autoneg_pkg::flag_state_type st_next;

  always_comb begin
    st_next = st_reg;
    // Set beats a clear in the same cycle
    if (set_in) begin
      st_next.flag = 1'b1;
    end else if (clr_in) begin
      st_next.flag = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flag_out = st_reg.flag;

endmodule // latch_flag

`default_nettype wire

// ==== hw/autoneg_ability_registers.sv ====

`timescale 1ns/1ps
`default_nettype none

`include "autoneg_consts.svh"

module autoneg_ability_registers #(
  parameter logic [3:0] REV_ID = 4'h3 // Arbitrary revision value
) (
  input  wire logic        mclk_in,         // System clock, 100 MHz
  input  wire logic        reset_in,        // Async reset, high
  input  wire logic        mdc_in,          // Management clock pin
  input  wire logic        mdio_in,         // Management data pin in
  output logic             mdio_out,        // Management data pin out
  output logic             mdio_oe_out,     // Management data drive enable
  input  wire logic [4:0]  station_address_in, // Station address straps
  input  wire logic [2:0]  strap_in,        // 100FD, 10FD, 10HD straps
  input  wire logic        lp_valid_in,     // Partner base page pulse
  input  wire logic [15:0] lp_word_in,      // Partner base page word
  input  wire logic        par_fault_in,    // Parallel-detect fault pulse
  output logic [15:0]      adv_word_out     // Advertisement word
);

  autoneg_pkg::mgmt_state_type st_reg;
  autoneg_pkg::mgmt_state_type st_next;

  pin_bus_if pins ();

  assign pins.mdc_raw   = mdc_in;
  assign pins.mdio_raw  = mdio_in;
  assign pins.addr_raw  = station_address_in;
  assign pins.strap_raw = strap_in;

  pin_sync u_sync (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .pins     (pins.sync)
  );

  logic        mdc_edge;
  logic [11:0] hdr_w;
  logic        hdr_done;
  logic        addr_hit;
  logic        rd_load;
  logic        rd_clr;
  logic [15:0] rd_word;
  logic        pdf_q;
  logic        pr_q;

  assign mdc_edge = pins.mdc & ~st_reg.mdc_prev;
  assign hdr_w    = {st_reg.sh[10:0], pins.mdio};
  assign hdr_done = mdc_edge && (st_reg.state == autoneg_pkg::HDR)
                    && (st_reg.cnt == `HDR_LAST);
  assign addr_hit = (hdr_w[9:5] == pins.addr);
  assign rd_load  = hdr_done && addr_hit && (hdr_w[11:10] == `OP_RD);
  assign rd_clr   = rd_load && (hdr_w[4:0] == `EXP_OFS);

  latch_flag u_pdf (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .set_in   (par_fault_in),
    .clr_in   (rd_clr),
    .flag_out (pdf_q)
  );

  latch_flag u_pr (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .set_in   (lp_valid_in),
    .clr_in   (rd_clr),
    .flag_out (pr_q)
  );

  // Word seen by a read at the header's register offset
  always_comb begin
    rd_word = 16'h0000;
    case (hdr_w[4:0])
      `ADV_OFS: begin
        rd_word[`ADV_NP_BIT]     = 1'b0;
        rd_word[`ADV_RF_BIT]     = st_reg.adv_rf;
        rd_word[`ADV_PAUSE_HI:`ADV_PAUSE_LO] = st_reg.adv_pause;
        rd_word[`ADV_T4_BIT]     = 1'b0;
        rd_word[`ADV_100FD_BIT]  = st_reg.adv_100fd;
        rd_word[`ADV_100HD_BIT]  = st_reg.adv_100hd;
        rd_word[`ADV_10FD_BIT]   = st_reg.adv_10fd;
        rd_word[`ADV_10HD_BIT]   = st_reg.adv_10hd;
        rd_word[`SEL_HI:0]       = st_reg.adv_sel;
      end
      `LP_OFS: begin
        rd_word[`LP_ACK_BIT]     = st_reg.lp_ack;
        rd_word[`LP_RF_BIT]      = st_reg.lp_rf;
        rd_word[`LP_PAUSE_BIT]   = st_reg.lp_pause;
        rd_word[`LP_T4_BIT]      = 1'b0;
        rd_word[`ADV_100FD_BIT]  = st_reg.lp_100fd;
        rd_word[`ADV_100HD_BIT]  = st_reg.lp_100hd;
        rd_word[`ADV_10FD_BIT]   = st_reg.lp_10fd;
        rd_word[`ADV_10HD_BIT]   = st_reg.lp_10hd;
        rd_word[`SEL_HI:0]       = st_reg.lp_sel;
      end
      `EXP_OFS: begin
        rd_word[`EXP_PDF_BIT]    = pdf_q;
        rd_word[`EXP_LPNP_BIT]   = st_reg.exp_lpnp;
        rd_word[`EXP_NPA_BIT]    = 1'b0;
        rd_word[`EXP_PR_BIT]     = pr_q;
        rd_word[`EXP_LPAN_BIT]   = st_reg.exp_lpan;
      end
      `REV_OFS: begin
        rd_word[`REV_LSB+3:`REV_LSB] = REV_ID;
      end
      default: begin
        rd_word = 16'h0000;
      end
    endcase
  end

  always_comb begin
    st_next          = st_reg;
    st_next.mdc_prev = pins.mdc;

    // Straps settle through the synchroniser, then load once
    if (!st_reg.strap_done) begin
      if (st_reg.strap_cnt == `STRAP_WAIT) begin
        st_next.adv_100fd  = pins.strap[2];
        st_next.adv_10fd   = pins.strap[1];
        st_next.adv_10hd   = pins.strap[0];
        st_next.strap_done = 1'b1;
      end else begin
        st_next.strap_cnt = st_reg.strap_cnt + 2'h1;
      end
    end

    // Capture of the partner base page
    if (lp_valid_in) begin
      st_next.lp_ack   = 1'b1;
      st_next.lp_rf    = lp_word_in[`LP_RF_BIT];
      st_next.lp_pause = lp_word_in[`LP_PAUSE_BIT];
      st_next.lp_100fd = lp_word_in[`ADV_100FD_BIT];
      st_next.lp_100hd = lp_word_in[`ADV_100HD_BIT];
      st_next.lp_10fd  = lp_word_in[`ADV_10FD_BIT];
      st_next.lp_10hd  = lp_word_in[`ADV_10HD_BIT];
      st_next.lp_sel   = lp_word_in[`SEL_HI:0];
      st_next.exp_lpnp = lp_word_in[`LP_NP_BIT];
      st_next.exp_lpan = 1'b1;
    end

    if (mdc_edge) begin
      case (st_reg.state)
        autoneg_pkg::PRE: begin
          if (pins.mdio) begin
            if (st_reg.ones != `PRE_ONES) begin
              st_next.ones = st_reg.ones + 6'h01;
            end
          end else if (st_reg.ones == `PRE_ONES) begin
            st_next.state = autoneg_pkg::START;
          end else begin
            st_next.ones = 6'h00;
          end
        end
        autoneg_pkg::START: begin
          st_next.ones = 6'h00;
          st_next.cnt  = 5'h00;
          if (pins.mdio) begin
            st_next.state = autoneg_pkg::HDR;
          end else begin
            st_next.state = autoneg_pkg::PRE;
          end
        end
        autoneg_pkg::HDR: begin
          st_next.sh  = {st_reg.sh[14:0], pins.mdio};
          st_next.cnt = st_reg.cnt + 5'h01;
          if (hdr_done) begin
            st_next.reg_ofs = hdr_w[4:0];
            st_next.cnt     = 5'h00;
            if (rd_load) begin
              st_next.sh    = rd_word;
              st_next.state = autoneg_pkg::TA;
            end else if (addr_hit && (hdr_w[11:10] == `OP_WR)) begin
              st_next.state = autoneg_pkg::WTA;
            end else begin
              st_next.state = autoneg_pkg::PRE;
            end
          end
        end
        autoneg_pkg::TA: begin
          // Second turnaround bit driven low
          st_next.mdio_oe = 1'b1;
          st_next.mdio_o  = 1'b0;
          st_next.state   = autoneg_pkg::RDATA;
        end
        autoneg_pkg::RDATA: begin
          if (st_reg.cnt == `DATA_END) begin
            st_next.mdio_oe = 1'b0;
            st_next.mdio_o  = 1'b0;
            st_next.state   = autoneg_pkg::PRE;
          end else begin
            st_next.mdio_o = st_reg.sh[15];
            st_next.sh     = {st_reg.sh[14:0], 1'b0};
            st_next.cnt    = st_reg.cnt + 5'h01;
          end
        end
        autoneg_pkg::WTA: begin
          st_next.cnt = st_reg.cnt + 5'h01;
          if (st_reg.cnt == 5'h01) begin
            st_next.cnt   = 5'h00;
            st_next.state = autoneg_pkg::WDATA;
          end
        end
        autoneg_pkg::WDATA: begin
          st_next.sh  = {st_reg.sh[14:0], pins.mdio};
          st_next.cnt = st_reg.cnt + 5'h01;
          if (st_reg.cnt == `DATA_LAST) begin
            st_next.state = autoneg_pkg::PRE;
            if (st_reg.reg_ofs == `ADV_OFS) begin
              st_next.adv_rf    = st_reg.sh[`ADV_RF_BIT-1];
              st_next.adv_pause = st_reg.sh[`ADV_PAUSE_HI-1:`ADV_PAUSE_LO-1];
              st_next.adv_100fd = st_reg.sh[`ADV_100FD_BIT-1];
              st_next.adv_100hd = st_reg.sh[`ADV_100HD_BIT-1];
              st_next.adv_10fd  = st_reg.sh[`ADV_10FD_BIT-1];
              st_next.adv_10hd  = st_reg.sh[`ADV_10HD_BIT-1];
              st_next.adv_sel   = {st_reg.sh[3:0], pins.mdio};
            end
          end
        end
        default: begin
          st_next.state   = autoneg_pkg::PRE;
          st_next.mdio_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      st_reg           <= '0;
      st_reg.state     <= autoneg_pkg::PRE;
      st_reg.adv_pause <= `PAUSE_RST;
      st_reg.adv_100hd <= `HD100_RST;
      st_reg.adv_sel   <= `SEL_RST;
      st_reg.lp_sel    <= `SEL_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign mdio_out     = st_reg.mdio_o;
  assign mdio_oe_out  = st_reg.mdio_oe;
  assign adv_word_out = {1'b0, 1'b0, st_reg.adv_rf, 1'b0, st_reg.adv_pause, 1'b0,
                         st_reg.adv_100fd, st_reg.adv_100hd, st_reg.adv_10fd,
                         st_reg.adv_10hd, st_reg.adv_sel};

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);

  sequence rd_of_s(logic [4:0] ofs);
    rd_load && (hdr_w[4:0] == ofs);
  endsequence

  sequence quiet_flags_s;
    !par_fault_in && !lp_valid_in;
  endsequence

  adv_np_zero_a : assert property (
    rd_of_s(`ADV_OFS) |=> !st_reg.sh[15] && (st_reg.state == autoneg_pkg::TA))
    else $error("advertised next-page bit not zero");

  adv_t4_zero_a : assert property (
    rd_of_s(`ADV_OFS) |=> !st_reg.sh[9])
    else $error("advertised T4 bit not zero");

  lp_t4_zero_a : assert property (
    rd_of_s(`LP_OFS) |=> !st_reg.sh[9])
    else $error("partner T4 bit not zero");

  rev_field_a : assert property (
    rd_of_s(`REV_OFS) |=> st_reg.sh == {6'h00, REV_ID, 6'h00})
    else $error("revision word wrong");

  lp_capture_a : assert property (
    lp_valid_in |=> st_reg.lp_ack && st_reg.exp_lpan
                    && (st_reg.lp_sel == $past(lp_word_in[4:0]))
                    && (st_reg.lp_10hd == $past(lp_word_in[5])))
    else $error("partner page not captured");

  pdf_latch_a : assert property (
    par_fault_in |=> pdf_q ##1 (pdf_q || $past(rd_clr)))
    else $error("parallel fault flag not latched");

  page_rx_a : assert property (
    lp_valid_in |=> pr_q)
    else $error("page received flag not set");

  read_clear_a : assert property (
    rd_of_s(`EXP_OFS) ##0 quiet_flags_s |=> !pdf_q && !pr_q
      && (st_reg.sh[1] == $past(pr_q)) && (st_reg.sh[4] == $past(pdf_q)))
    else $error("read did not return and clear flags");

  addr_miss_a : assert property (
    hdr_done && !addr_hit |=> ((st_reg.state == autoneg_pkg::PRE) && !mdio_oe_out) [*3])
    else $error("frame for another station answered");

  strap_load_a : assert property (
    $rose(st_reg.strap_done) |-> (st_reg.adv_100fd == $past(pins.strap[2]))
                                 && (st_reg.adv_10hd == $past(pins.strap[0])))
    else $error("strap abilities not loaded");

  ack_sticky_a : assert property (
    st_reg.lp_ack |=> st_reg.lp_ack)
    else $error("partner acknowledge dropped");

  // Partner fields move only with a received page
  lp_hold_a : assert property (
    !lp_valid_in |=> $stable(st_reg.lp_sel) && $stable(st_reg.lp_rf)
                     && $stable(st_reg.lp_pause))
    else $error("partner field changed without a page");

  drive_window_a : assert property (
    mdio_oe_out |-> (st_reg.state == autoneg_pkg::RDATA))
    else $error("data line driven outside a read");

  // Straps load once; afterwards only a write frame moves the word
  adv_hold_a : assert property (
    st_reg.strap_done && !(mdc_edge && (st_reg.state == autoneg_pkg::WDATA))
    |=> $stable(adv_word_out))
    else $error("advertisement changed without a write");

endmodule // autoneg_ability_registers

`default_nettype wire

// ==== testbench/mgmt_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module mgmt_host_model (
  input  wire logic mclk_in,     // Bench clock
  input  wire logic mdio_in,     // Resolved data wire
  output var  logic mdc_out,     // Management clock, idle low
  output var  logic mdio_out,    // Host data
  output var  logic mdio_oe_out  // Host drive enable
);
  initial begin
    mdc_out = 1'b0;
    mdio_out = 1'b1;
    mdio_oe_out = 1'b0;
  end

  // Data set while MDC low, wire sampled at the rise
  task automatic bit_cycle(input logic drv, input logic val, output logic smp);
    @(posedge mclk_in) #1;
    mdc_out = 1'b0;
    mdio_oe_out = drv;
    mdio_out = val;
    repeat (5) @(posedge mclk_in);
    #1 mdc_out = 1'b1;
    smp = mdio_in;
    repeat (5) @(posedge mclk_in);
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ofs,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic        smp;
    hdr = {2'b01, op, phy, ofs};
    rd = 16'h0000;
    for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, smp);
    for (int i = 13; i >= 0; i--) bit_cycle(1'b1, hdr[i], smp);
    if (op == 2'h2) begin
      bit_cycle(1'b0, 1'b0, smp);
      bit_cycle(1'b0, 1'b0, smp);
      for (int i = 15; i >= 0; i--) begin
        bit_cycle(1'b0, 1'b0, smp);
        rd[i] = smp;
      end
    end else begin
      bit_cycle(1'b1, 1'b1, smp);
      bit_cycle(1'b1, 1'b0, smp);
      for (int i = 15; i >= 0; i--) bit_cycle(1'b1, wd[i], smp);
    end
    // Clock stands low and the line is released between frames
    @(posedge mclk_in) #1;
    mdc_out = 1'b0;
    mdio_oe_out = 1'b0;
    repeat (8) @(posedge mclk_in);
  endtask
endmodule // mgmt_host_model

`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam logic [3:0] REV = 4'h3; // Arbitrary revision value
  localparam logic [4:0] STN = 5'h0a;

  typedef struct {
    logic        wr;
    logic [4:0]  ofs;
    logic [15:0] wd;
    logic [15:0] exp;
  } row_type;

  logic        mclk;
  logic        reset;
  logic        mdc;
  logic        host_d;
  logic        host_oe;
  logic        dev_d;
  logic        dev_oe;
  logic        mdio_wire;
  logic        lp_valid;
  logic        par_fault;
  int          oe_cycles = 0;
  int          oe_mark;
  logic [2:0]  strap;
  logic [15:0] lp_word;
  logic [15:0] adv_word;
  logic [15:0] rd;
  int          fail_count;
  int          samples_checked;
  row_type     rows [13] = '{
    '{1'b0, 5'h04, 16'h0000, 16'h01a1},
    '{1'b0, 5'h05, 16'h0000, 16'h0001},
    '{1'b0, 5'h06, 16'h0000, 16'h0000},
    '{1'b0, 5'h10, 16'h0000, {6'h00, REV, 6'h00}},
    '{1'b0, 5'h07, 16'h0000, 16'h0000},
    '{1'b1, 5'h04, 16'hffff, 16'h2dff},
    '{1'b1, 5'h04, 16'h0000, 16'h0000},
    '{1'b1, 5'h04, 16'h0401, 16'h0401},
    '{1'b1, 5'h04, 16'h0801, 16'h0801},
    '{1'b1, 5'h04, 16'h0c01, 16'h0c01},
    '{1'b1, 5'h04, 16'h2001, 16'h2001},
    '{1'b1, 5'h05, 16'hffff, 16'h0001},
    '{1'b1, 5'h06, 16'hffff, 16'h0000}
  };

  // Open line with pull-up when neither side drives
  assign mdio_wire = dev_oe ? dev_d : (host_oe ? host_d : 1'b1);

  autoneg_ability_registers #(.REV_ID(REV)) i_autoneg_ability_registers (
    .mclk_in            (mclk),
    .reset_in           (reset),
    .mdc_in             (mdc),
    .mdio_in            (mdio_wire),
    .mdio_out           (dev_d),
    .mdio_oe_out        (dev_oe),
    .station_address_in (STN),
    .strap_in           (strap),
    .lp_valid_in        (lp_valid),
    .lp_word_in         (lp_word),
    .par_fault_in       (par_fault),
    .adv_word_out       (adv_word)
  );

  mgmt_host_model i_mgmt_host_model (
    .mclk_in     (mclk),
    .mdio_in     (mdio_wire),
    .mdc_out     (mdc),
    .mdio_out    (host_d),
    .mdio_oe_out (host_oe)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Counts every cycle in which the device drives the data line
  always @(posedge mclk) begin
    if (dev_oe === 1'b1) oe_cycles <= oe_cycles + 1;
  end

  task give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task check_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task rd_reg(input logic [4:0] phy, input logic [4:0] ofs, output logic [15:0] d);
    i_mgmt_host_model.frame(2'h2, phy, ofs, 16'h0000, d);
  endtask

  task wr_reg(input logic [4:0] phy, input logic [4:0] ofs, input logic [15:0] d);
    logic [15:0] unused;
    i_mgmt_host_model.frame(2'h1, phy, ofs, d, unused);
  endtask

  task pulse(input logic v, input logic [15:0] w, input logic f);
    @(posedge mclk) #1;
    lp_valid = v;
    lp_word = w;
    par_fault = f;
    @(posedge mclk) #1;
    lp_valid = 1'b0;
    par_fault = 1'b0;
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    fail_count++;
    $display("MISMATCH t=%0t run timed out", $time);
    give_verdict;
  end

  initial begin
    reset = 1'b1;
    strap = 3'b101;
    lp_valid = 1'b0;
    lp_word = 16'h0000;
    par_fault = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge mclk);
    #1 reset = 1'b0;
    repeat (10) @(posedge mclk);

    foreach (rows[i]) begin
      if (rows[i].wr) wr_reg(STN, rows[i].ofs, rows[i].wd);
      rd_reg(STN, rows[i].ofs, rd);
      check_word(rd, rows[i].exp, "row read");
      if (rows[i].ofs == 5'h04) check_word(adv_word, rows[i].exp, "adv word");
    end
    $display("test table done");

    pulse(1'b1, 16'hffff, 1'b0);
    pulse(1'b0, 16'h0000, 1'b1);
    rd_reg(STN, 5'h05, rd);
    check_word(rd, 16'h65ff, "partner word");
    rd_reg(STN, 5'h06, rd);
    check_word(rd, 16'h001b, "expansion set");
    rd_reg(STN, 5'h06, rd);
    check_word(rd, 16'h0009, "expansion cleared");
    pulse(1'b1, 16'h0021, 1'b0);
    rd_reg(STN, 5'h05, rd);
    check_word(rd, 16'h4021, "partner second");
    rd_reg(STN, 5'h06, rd);
    check_word(rd, 16'h0003, "expansion second");
    rd_reg(STN, 5'h06, rd);
    check_word(rd, 16'h0001, "expansion again");
    $display("test partner page done");

    oe_mark = oe_cycles;
    wr_reg(STN ^ 5'h01, 5'h04, 16'h0000);
    // Unknown opcode to our own station must be ignored
    i_mgmt_host_model.frame(2'h3, STN, 5'h04, 16'h0000, rd);
    rd_reg(STN ^ 5'h01, 5'h04, rd);
    check_word(rd, 16'hffff, "foreign read");
    check_bit(oe_cycles == oe_mark, 1'b1, "foreign drive");
    rd_reg(STN, 5'h04, rd);
    check_word(rd, 16'h2001, "foreign write");
    $display("test address done");

    @(posedge mclk) #1;
    strap = 3'b010;
    reset = 1'b1;
    repeat (2) @(posedge mclk);
    check_word(adv_word, 16'h0081, "adv in reset");
    #1 reset = 1'b0;
    repeat (10) @(posedge mclk);
    check_word(adv_word, 16'h00c1, "adv straps");
    rd_reg(STN, 5'h05, rd);
    check_word(rd, 16'h0001, "partner reset");
    rd_reg(STN, 5'h06, rd);
    check_word(rd, 16'h0000, "expansion reset");
    $display("test second reset done");
    give_verdict;
  end
endmodule // tb_top

`default_nettype wire
